// File: inc/tmr_pkg.sv
package tmr_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE_CTRL = 16'hffba;
  localparam logic [15:0] ADDR_PRESCALER = 16'hffbb;
  localparam logic [15:0] ADDR_CAPCMP_CTRL = 16'hffbc;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OVF_BIT = 0;
  localparam int OP_MODE_LO = 2;
  localparam int OP_MODE_HI = 3;
  localparam int CAPSEL_BIT = 2;
  localparam int CLK_SEL_LO = 0;
  localparam int CLK_SEL_HI = 1;
  localparam int CLK_SEL_B2 = 7;
  localparam int EDGE_SEL_LO = 4;
  localparam int EDGE_SEL_HI = 5;

  // ----------------------------------------------------------------
  // modes, edges, clock sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMR_MODE_STOP = 2'b00,
    TMR_MODE_FREE = 2'b01,
    TMR_MODE_PIN_CLEAR = 2'b10,
    TMR_MODE_MATCH_CLEAR = 2'b11
  } tmr_mode_e;

  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b11;

  localparam logic [2:0] CLK_PERIPH = 3'h0;
  localparam logic [2:0] CLK_DIV2 = 3'h1;
  localparam logic [2:0] CLK_DIV4 = 3'h2;
  localparam logic [2:0] CLK_DIV16 = 3'h3;
  localparam logic [2:0] CLK_DIV256 = 3'h4;
  localparam logic [2:0] CLK_SUB = 3'h5;
  localparam logic [2:0] CLK_PIN = 3'h6;
  localparam logic [2:0] CLK_NEIGHBOUR = 3'h7;

  localparam logic [7:0] MASK_DIV2 = 8'h01;
  localparam logic [7:0] MASK_DIV4 = 8'h03;
  localparam logic [7:0] MASK_DIV16 = 8'h0f;
  localparam logic [7:0] MASK_DIV256 = 8'hff;

  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
endpackage

// File: src/tmr_edge_detect.sv
`timescale 1ns/1ps
module tmr_edge_detect (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // control
  input wire logic i_run,
  input wire logic [1:0] i_edge_sel,
  // pin
  input wire logic i_pin,
  // result
  output logic o_valid_edge
);
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;
  logic run_d_reg;
  logic first_done_reg;
  logic change;
  logic first_hit;

  function automatic logic edge_ok(input logic [1:0] sel, input logic new_lvl);
    edge_ok = (sel == tmr_pkg::EDGE_BOTH) || (sel == tmr_pkg::EDGE_RISE && new_lvl) ||
      (sel == tmr_pkg::EDGE_FALL && !new_lvl);
  endfunction

  // ----------------------------------------------------------------
  // synchroniser and filter
  // ----------------------------------------------------------------
  // two agreeing samples also reject short noise
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= i_pin; // see R24
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign change = (sync2_reg == sync3_reg) && (sync3_reg != level_reg);
  // high pin at the very first start reads as a rising edge
  assign first_hit = i_run && !run_d_reg && !first_done_reg && level_reg &&
    (i_edge_sel == tmr_pkg::EDGE_RISE || i_edge_sel == tmr_pkg::EDGE_BOTH); // see R17

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      level_reg <= 1'b0;
      run_d_reg <= 1'b0;
      first_done_reg <= 1'b0;
      o_valid_edge <= 1'b0;
    end else begin
      run_d_reg <= i_run;
      if (change) begin
        level_reg <= sync3_reg;
      end
      if (i_run) begin
        first_done_reg <= 1'b1; // see R17
      end
      o_valid_edge <= i_run && ((change && edge_ok(i_edge_sel, sync3_reg)) || first_hit); // see R12
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_no_edge_stopped;
    @(posedge i_sys_clk) disable iff (!i_rst_b) !i_run |=> !o_valid_edge;
  endproperty
  a_no_edge_stopped: assert property (p_no_edge_stopped) else $error("edge reported while stopped"); // see R12

  property p_fall_only;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_run && run_d_reg && i_edge_sel == tmr_pkg::EDGE_FALL && change && sync3_reg) |=> !o_valid_edge;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("rising edge taken in falling mode"); // see R12
endmodule

// File: src/tmr_core.sv
`timescale 1ns/1ps
// What this block does
// R1 - mode 00 stops counter, stops its clock, holds it at zero
// R2 - mode 01 free run, 10 clear on pin edge, 11 clear on compare
// R3 - counting starts when mode becomes nonzero, stops when written 00
// R4 - software only stops the timer or clears overflow while running
// R5 - overflow flag sets when counter rolls FFFFH to 0000H
// R6 - overflow clears by writing 0 or by mode 00
// R7 - writing 1 to overflow flag sets it
// R8 - mode register resets 00H; mode bits 3:2, overflow bit 0, rest zero
// R9 - control bit 2 selects compare (0) or capture (1); resets 00H
// R10 - software leaves capture/compare control alone while running
// R11 - capture trigger pulse lasts two count clocks longer than period
// R12 - edge select bits 5:4: 00 fall, 01 rise, 11 both
// R13 - clock select: periph, /2, /4, /16, /256, sub clock, pin edges
// R14 - clock select 111 counts neighbour timer output
// R15 - prescaler not rewritten while running; resets 00H
// R16 - pin clock excludes pin clear mode and pin capture
// R17 - first start with high pin detects rising edge, restart does not
// R18 - pin clock pulses longer than two peripheral clocks
// R19 - no pin clock during pulse width measurement
// R20 - counter increments on each selected count clock
// R21 - primary compare matched continuously, match raises interrupt request
// R22 - compare clear mode resets counter to 0000H on match
// R23 - capture mode copies counter into second register on trigger
// R24 - pin synchronised before edge detection
module tmr_core #(
  parameter int PRESCALE_W = 8
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // cpu register port
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // compare values
  input wire logic [15:0] i_primary_compare,
  input wire logic [15:0] i_second_compare,
  // count sources
  input wire logic i_sub_clk_tick,
  input wire logic i_neighbour_tick,
  input wire logic i_event_input_pin,
  // timer state
  output logic [15:0] o_count_register,
  output logic [15:0] o_second_capture_compare,
  output logic o_primary_match_irq,
  output logic o_second_match_irq
);
  logic [1:0] op_mode_reg;
  logic overflow_flag_reg;
  logic second_reg_capture_sel_reg;
  logic [2:0] clk_sel_reg;
  logic [1:0] edge_sel_reg;
  logic [PRESCALE_W-1:0] div_reg;
  logic [15:0] count_reg;
  logic running;
  logic valid_edge;
  logic tick;
  logic primary_hit;
  logic clear_now;
  logic roll_over;
  logic wr_mode;
  logic wr_capcmp;
  logic wr_prescale;

  function automatic logic div_tick(input logic [PRESCALE_W-1:0] cnt, input logic [7:0] mask);
    div_tick = (cnt[7:0] & mask) == mask;
  endfunction

  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] target);
    addr_hit = a == target;
  endfunction

  assign running = op_mode_reg != tmr_pkg::TMR_MODE_STOP; // see R3
  assign wr_mode = i_wr_en && addr_hit(i_addr, tmr_pkg::ADDR_MODE_CTRL);
  assign wr_capcmp = i_wr_en && addr_hit(i_addr, tmr_pkg::ADDR_CAPCMP_CTRL);
  assign wr_prescale = i_wr_en && addr_hit(i_addr, tmr_pkg::ADDR_PRESCALER);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // bit writes arrive as whole bytes from the cpu read-modify-write
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      op_mode_reg <= tmr_pkg::TMR_MODE_STOP; // see R8
    end else if (wr_mode) begin
      op_mode_reg <= i_wdata[tmr_pkg::OP_MODE_HI:tmr_pkg::OP_MODE_LO]; // see R3
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      second_reg_capture_sel_reg <= 1'b0; // see R9
    end else if (wr_capcmp) begin
      second_reg_capture_sel_reg <= i_wdata[tmr_pkg::CAPSEL_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_sel_reg <= tmr_pkg::CLK_PERIPH; // see R15
      edge_sel_reg <= tmr_pkg::EDGE_FALL;
    end else if (wr_prescale) begin
      clk_sel_reg <= {i_wdata[tmr_pkg::CLK_SEL_B2], i_wdata[tmr_pkg::CLK_SEL_HI:tmr_pkg::CLK_SEL_LO]};
      edge_sel_reg <= i_wdata[tmr_pkg::EDGE_SEL_HI:tmr_pkg::EDGE_SEL_LO]; // see R12
    end
  end

  // hardware set wins over a same-cycle software clear
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      overflow_flag_reg <= 1'b0;
    end else if (roll_over) begin
      overflow_flag_reg <= 1'b1; // see R5
    end else if (wr_mode && i_wdata[tmr_pkg::OP_MODE_HI:tmr_pkg::OP_MODE_LO] == tmr_pkg::TMR_MODE_STOP) begin
      overflow_flag_reg <= 1'b0; // see R6
    end else if (wr_mode) begin
      overflow_flag_reg <= i_wdata[tmr_pkg::OVF_BIT]; // see R7
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= tmr_pkg::REG_RESET;
    end else if (i_rd_en) begin
      if (addr_hit(i_addr, tmr_pkg::ADDR_MODE_CTRL)) begin
        o_rdata <= {4'h0, op_mode_reg, 1'b0, overflow_flag_reg}; // see R8
      end else if (addr_hit(i_addr, tmr_pkg::ADDR_PRESCALER)) begin
        o_rdata <= {clk_sel_reg[2], 1'b0, edge_sel_reg, 2'h0, clk_sel_reg[1:0]};
      end else if (addr_hit(i_addr, tmr_pkg::ADDR_CAPCMP_CTRL)) begin
        o_rdata <= {5'h00, second_reg_capture_sel_reg, 2'h0}; // see R9
      end else begin
        o_rdata <= tmr_pkg::READ_UNMAPPED;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin edge and prescaler
  // ----------------------------------------------------------------
  tmr_edge_detect tmr_edge_detect_i (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_run(running),
    .i_edge_sel(edge_sel_reg),
    .i_pin(i_event_input_pin),
    .o_valid_edge(valid_edge)
  );

  // divider held at zero while stopped, so the clock is withheld
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_reg <= '0;
    end else if (!running) begin
      div_reg <= '0; // see R1
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_comb begin
    case (clk_sel_reg) // see R13
      tmr_pkg::CLK_PERIPH: tick = 1'b1;
      tmr_pkg::CLK_DIV2: tick = div_tick(div_reg, tmr_pkg::MASK_DIV2);
      tmr_pkg::CLK_DIV4: tick = div_tick(div_reg, tmr_pkg::MASK_DIV4);
      tmr_pkg::CLK_DIV16: tick = div_tick(div_reg, tmr_pkg::MASK_DIV16);
      tmr_pkg::CLK_DIV256: tick = div_tick(div_reg, tmr_pkg::MASK_DIV256);
      tmr_pkg::CLK_SUB: tick = i_sub_clk_tick;
      tmr_pkg::CLK_PIN: tick = valid_edge;
      default: tick = i_neighbour_tick; // see R14
    endcase
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  assign primary_hit = running && tick && count_reg == i_primary_compare; // see R21
  assign clear_now = (op_mode_reg == tmr_pkg::TMR_MODE_MATCH_CLEAR && primary_hit) ||
    (op_mode_reg == tmr_pkg::TMR_MODE_PIN_CLEAR && valid_edge); // see R2
  assign roll_over = running && tick && !clear_now && count_reg == tmr_pkg::COUNT_MAX; // see R5

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_reg <= tmr_pkg::COUNT_ZERO;
    end else if (!running) begin
      count_reg <= tmr_pkg::COUNT_ZERO; // see R1
    end else if (clear_now) begin
      count_reg <= tmr_pkg::COUNT_ZERO; // see R22
    end else if (tick) begin
      count_reg <= count_reg + tmr_pkg::COUNT_ONE; // see R20
    end
  end

  // captured value stays until the next trigger
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_second_capture_compare <= tmr_pkg::COUNT_ZERO;
    end else if (running && second_reg_capture_sel_reg && valid_edge) begin
      o_second_capture_compare <= count_reg; // see R23
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count_register <= tmr_pkg::COUNT_ZERO;
      o_primary_match_irq <= 1'b0;
      o_second_match_irq <= 1'b0;
    end else begin
      o_count_register <= count_reg;
      o_primary_match_irq <= primary_hit; // see R21
      o_second_match_irq <= running && tick && !second_reg_capture_sel_reg && count_reg == i_second_compare;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_count_step;
    running && tick && !clear_now;
  endsequence

  property p_stop_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_b) !running |=> count_reg == tmr_pkg::COUNT_ZERO;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("counter not cleared while stopped"); // see R1

  property p_increment;
    @(posedge i_sys_clk) disable iff (!i_rst_b) s_count_step |=> count_reg == $past(count_reg) + tmr_pkg::COUNT_ONE;
  endproperty
  a_increment: assert property (p_increment) else $error("counter missed a count clock"); // see R20

  property p_match_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (op_mode_reg == tmr_pkg::TMR_MODE_MATCH_CLEAR && primary_hit) |=> count_reg == tmr_pkg::COUNT_ZERO;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("no clear on compare match"); // see R22

  property p_pin_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (op_mode_reg == tmr_pkg::TMR_MODE_PIN_CLEAR && valid_edge) |=> count_reg == tmr_pkg::COUNT_ZERO;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("no clear on pin edge"); // see R2

  property p_overflow;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (s_count_step and count_reg == tmr_pkg::COUNT_MAX) |=> overflow_flag_reg && count_reg == tmr_pkg::COUNT_ZERO;
  endproperty
  a_overflow: assert property (p_overflow) else $error("roll over did not set overflow"); // see R5

  property p_ovf_stop;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_mode && !roll_over && i_wdata[tmr_pkg::OP_MODE_HI:tmr_pkg::OP_MODE_LO] == tmr_pkg::TMR_MODE_STOP)
      |=> !overflow_flag_reg;
  endproperty
  a_ovf_stop: assert property (p_ovf_stop) else $error("overflow kept after stop"); // see R6

  property p_ovf_sw_set;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_mode && i_wdata[tmr_pkg::OVF_BIT] && i_wdata[tmr_pkg::OP_MODE_HI:tmr_pkg::OP_MODE_LO] != 2'b00)
      |=> overflow_flag_reg;
  endproperty
  a_ovf_sw_set: assert property (p_ovf_sw_set) else $error("software set of overflow lost"); // see R7

  property p_capture;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (running && second_reg_capture_sel_reg && valid_edge) |=> o_second_capture_compare == $past(count_reg);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // see R23

  property p_primary_irq;
    @(posedge i_sys_clk) disable iff (!i_rst_b) primary_hit |=> o_primary_match_irq;
  endproperty
  a_primary_irq: assert property (p_primary_irq) else $error("match request missing"); // see R21

  property p_div2;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (running && clk_sel_reg == tmr_pkg::CLK_DIV2 && tick) |=> !tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two ticked twice"); // see R13
endmodule

// File: tb/tmr_pin_source.sv
`timescale 1ns/1ps
module tmr_pin_source (
  // clock
  input wire logic i_sys_clk,
  // pin
  output logic o_pin
);
  // ----------------------------------------------------------------
  // event pin driver
  // ----------------------------------------------------------------
  // every level held at least this long: above two peripheral clocks,
  // and two cycles past the count clock used while capturing
  localparam int MIN_HOLD = 4;

  initial begin
    o_pin = 1'b0;
  end

  task automatic set_level(input logic v, input int hold);
    int n;
    n = (hold > MIN_HOLD) ? hold : MIN_HOLD;
    @(negedge i_sys_clk);
    o_pin = v;
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic pulse(input int hi, input int lo);
    set_level(1'b1, hi);
    set_level(1'b0, lo);
  endtask
endmodule

// File: tb/tmr_core_test.sv
`timescale 1ns/1ps
module tmr_core_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [15:0] i_primary_compare = 16'h0000;
  logic [15:0] i_second_compare = 16'h0000;
  logic i_sub_clk_tick = 1'b0;
  logic i_neighbour_tick = 1'b0;
  logic pin;
  logic [15:0] o_count_register;
  logic [15:0] o_second_capture_compare;
  logic o_primary_match_irq;
  logic o_second_match_irq;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int pm_cnt = 0;
  int sm_cnt = 0;
  logic [15:0] c0;
  logic [15:0] cap;
  logic seen_high;
  int divs [5] = '{1, 2, 4, 16, 256};
  logic [1:0] edges [3] = '{2'b00, 2'b01, 2'b11};

  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  tmr_core #(.PRESCALE_W(8)) tmr_core_i (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_primary_compare(i_primary_compare), .i_second_compare(i_second_compare),
    .i_sub_clk_tick(i_sub_clk_tick), .i_neighbour_tick(i_neighbour_tick),
    .i_event_input_pin(pin), .o_count_register(o_count_register),
    .o_second_capture_compare(o_second_capture_compare),
    .o_primary_match_irq(o_primary_match_irq), .o_second_match_irq(o_second_match_irq)
  );

  tmr_pin_source tmr_pin_source_i (.i_sys_clk(i_sys_clk), .o_pin(pin));

  // ----------------------------------------------------------------
  // monitors and timeout
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    cycles++;
    if (o_primary_match_irq === 1'b1) pm_cnt++;
    if (o_second_match_irq === 1'b1) sm_cnt++;
    if (cycles == 100000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_wr_en = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_sys_clk);
    i_wr_en = 1'b0;
  endtask

  task automatic rchk(input string name, input logic [15:0] a, input logic [7:0] exp);
    @(negedge i_sys_clk);
    i_rd_en = 1'b1;
    i_addr = a;
    @(negedge i_sys_clk);
    i_rd_en = 1'b0;
    @(negedge i_sys_clk);
    chk(name, {8'h00, exp}, {8'h00, o_rdata});
  endtask

  task automatic tick(input logic sub, input int n);
    repeat (n) begin
      @(negedge i_sys_clk);
      i_sub_clk_tick = sub;
      i_neighbour_tick = ~sub;
      @(negedge i_sys_clk);
      i_sub_clk_tick = 1'b0;
      i_neighbour_tick = 1'b0;
      cyc(2);
    end
  endtask

  // count clock source: 8 ticks of the chosen source, then stop clears the count
  task automatic rate(input logic [2:0] code);
    wr(tmr_pkg::ADDR_PRESCALER, {code[2], 3'b001, 2'b00, code[1:0]});
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h04);
    cyc(4);
    c0 = o_count_register;
    if (code == tmr_pkg::CLK_SUB) tick(1'b1, 8);
    else if (code == tmr_pkg::CLK_NEIGHBOUR) tick(1'b0, 8);
    else if (code == tmr_pkg::CLK_PIN) repeat (8) tmr_pin_source_i.pulse(4, 4);
    else cyc(8 * divs[code] - 6); // tail wait below completes 8 periods
    cyc(6);
    chk("count ticks", 16'h0008, o_count_register - c0);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    cyc(3);
    chk("count stopped", 16'h0000, o_count_register);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    i_rst_b = 1'b1;
    rchk("mode reset", tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    rchk("prescaler reset", tmr_pkg::ADDR_PRESCALER, 8'h00);
    rchk("capcmp reset", tmr_pkg::ADDR_CAPCMP_CTRL, 8'h00);
    wr(tmr_pkg::ADDR_PRESCALER, 8'hff);
    rchk("prescaler layout", tmr_pkg::ADDR_PRESCALER, 8'hb3);
    wr(tmr_pkg::ADDR_CAPCMP_CTRL, 8'hff);
    rchk("capcmp layout", tmr_pkg::ADDR_CAPCMP_CTRL, 8'h04);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h01);
    rchk("mode stop clears flag", tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    wr(16'h1234, 8'hff);
    rchk("unmapped", 16'h1234, tmr_pkg::READ_UNMAPPED);
    wr(tmr_pkg::ADDR_CAPCMP_CTRL, 8'h00);
    // pin low on this first start, so no start-up edge is injected
    for (int k = 0; k < 8; k++) rate(3'(k));
    // interval mode with both compare matches, period 3
    i_primary_compare = 16'h0002;
    i_second_compare = 16'h0001;
    wr(tmr_pkg::ADDR_PRESCALER, 8'h00);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h0c);
    cyc(10);
    c0 = 16'(pm_cnt);
    cap = 16'(sm_cnt);
    seen_high = 1'b0;
    repeat (30) begin
      cyc(1);
      if (o_count_register > 16'h0002) seen_high = 1'b1;
    end
    chk("match clear", 16'h0000, {15'h0, seen_high});
    chk("primary irqs", 16'd10, 16'(pm_cnt) - c0);
    chk("second irqs", 16'd10, 16'(sm_cnt) - cap);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    // pin clear mode, each edge selection (pin is not the count clock)
    foreach (edges[e]) begin
      wr(tmr_pkg::ADDR_PRESCALER, {2'b00, edges[e], 4'h0});
      wr(tmr_pkg::ADDR_MODE_CTRL, 8'h08);
      cyc(40);
      tmr_pin_source_i.set_level(1'b1, 8);
      chk("rise clear", {15'h0, edges[e] != 2'b00}, {15'h0, o_count_register < 16'd12});
      cyc(40);
      tmr_pin_source_i.set_level(1'b0, 8);
      chk("fall clear", {15'h0, edges[e] != 2'b01}, {15'h0, o_count_register < 16'd12});
      wr(tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    end
    // capture on rising pin edge, periph count clock (pin not a count clock)
    wr(tmr_pkg::ADDR_CAPCMP_CTRL, 8'h04);
    wr(tmr_pkg::ADDR_PRESCALER, 8'h10);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h04);
    cyc(40);
    c0 = o_count_register;
    tmr_pin_source_i.pulse(8, 8);
    cap = o_second_capture_compare;
    chk("capture window", 16'h0001, {15'h0, cap > c0 && cap < c0 + 16'd12});
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    wr(tmr_pkg::ADDR_CAPCMP_CTRL, 8'h00);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h04);
    cyc(20);
    tmr_pin_source_i.pulse(8, 8);
    chk("compare no capture", cap, o_second_capture_compare);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    // overflow flag
    wr(tmr_pkg::ADDR_PRESCALER, 8'h00);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h04);
    cyc(65545);
    rchk("overflow set", tmr_pkg::ADDR_MODE_CTRL, 8'h05);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h04);
    rchk("overflow cleared", tmr_pkg::ADDR_MODE_CTRL, 8'h04);
    // flag set together with the start, since R4 lets software only stop or clear overflow while running
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h05);
    rchk("overflow by write", tmr_pkg::ADDR_MODE_CTRL, 8'h05);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    rchk("overflow on stop", tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    // second reset: first start with pin high sees a rising edge, restart does not
    @(negedge i_sys_clk);
    i_rst_b = 1'b0;
    tmr_pin_source_i.set_level(1'b1, 10);
    i_rst_b = 1'b1;
    wr(tmr_pkg::ADDR_PRESCALER, 8'h92);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h04);
    cyc(10);
    chk("first start edge", 16'h0001, o_count_register);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h04);
    cyc(10);
    chk("restart no edge", 16'h0000, o_count_register);
    wr(tmr_pkg::ADDR_MODE_CTRL, 8'h00);
    tally_and_finish();
  end
endmodule
